// ===== shared/smbus_addr_regs.svh
`ifndef SMBUS_ADDR_REGS_SVH
`define SMBUS_ADDR_REGS_SVH

`define CLK_FREQ_MHZ       25
`define CLK_PERIOD_NS      40
`define T_TIMEOUT_MIN_US   25000
`define T_TIMEOUT_MAX_US   35000
`define T_SEXT_MAX_US      25000
`define T_MEXT_MAX_US      10000
`define T_SCL_HALF_NS      5000
`define ADDR_GRP0_BASE     7'h40
`define ADDR_GRP1_BASE     7'h10
`define ADDR_GRP2_BASE     7'h50
`define ADDR_GRP1_FIRST    5'h08
`define ADDR_GRP2_FIRST    5'h10
`define ADDR_COMBOS        27
`define PIN_WEIGHT_2       5'h09
`define PIN_WEIGHT_1       5'h03
`define BIT_LAST           4'h7
`define BIT_ACK            4'h8
`define BYTE_ADDR          2'h0
`define BYTE_LO            2'h1
`define BYTE_HI            2'h2
`define BYTE_MAX           2'h3

`endif

// ===== shared/smbus_pkg.sv
package smbus_pkg;

    typedef enum logic [1:0] {
        PIN_OPEN,
        PIN_LOW,
        PIN_HIGH
    } pin_level_e;

    typedef logic [6:0]         addr_t;
    typedef logic signed [15:0] word_t;

    typedef enum logic [2:0] {
        H_IDLE,
        H_START,
        H_LOW,
        H_RISE,
        H_HIGH,
        H_STOP1,
        H_STOP2
    } host_state_e;

endpackage : smbus_pkg

// ===== shared/smbus_if.sv
interface smbus_if;
    logic scl;
    logic sda;
    logic t_scl_o;
    logic t_scl_oe;
    logic t_sda_o;
    logic t_sda_oe;
    logic h_scl_o;
    logic h_scl_oe;
    logic h_sda_o;
    logic h_sda_oe;

    // Open-drain wired AND with a pull-up; drivers only ever pull low.
    assign scl = !((t_scl_oe && !t_scl_o) || (h_scl_oe && !h_scl_o));
    assign sda = !((t_sda_oe && !t_sda_o) || (h_sda_oe && !h_sda_o));

    modport target (input scl, input sda,
                    output t_scl_o, output t_scl_oe, output t_sda_o, output t_sda_oe);
    modport host   (input scl, input sda,
                    output h_scl_o, output h_scl_oe, output h_sda_o, output h_sda_oe);
endinterface : smbus_if

// ===== logic/smbus_target_end.sv
`include "smbus_addr_regs.svh"

// Summary of operation
// - Three tri-level pins select 27 addresses.
// - Sample pins after enable and power-good.
// - Seven-bit address from ordered table groups.
// - Clock low past 25 ms resets bus.
// - Cumulative stretch over 25 ms releases lines.
// - Host gives up after 25 ms waiting for clock release.
// - Telemetry returned as signed 16-bit word.
// - Host writes thresholds as signed words.
module smbus_target_end #(
    parameter int TIMEOUT_CYC = `T_TIMEOUT_MIN_US * `CLK_FREQ_MHZ,
    parameter int STRETCH_CYC = `T_SEXT_MAX_US * `CLK_FREQ_MHZ
) (
    input  wire logic                  clk_i,
    input  wire logic                  rst_n_i,
    input  wire logic                  enable_i,
    input  wire logic                  vdd_ok_i,
    input  wire logic                  vref_ok_i,
    input  wire smbus_pkg::pin_level_e addr_sel_pin0_i,
    input  wire smbus_pkg::pin_level_e addr_sel_pin1_i,
    input  wire smbus_pkg::pin_level_e addr_sel_pin2_i,
    input  wire smbus_pkg::word_t      telemetry_i,
    input  wire logic                  telemetry_valid_i,
    output smbus_pkg::addr_t           addr_o,
    output logic                       addr_valid_o,
    output smbus_pkg::word_t           threshold_o,
    output logic                       threshold_we_o,
    output logic                       telemetry_req_o,
    output logic                       bus_reset_o,
    smbus_if.target                    bus
);

    function automatic logic [4:0] pin_weight(input smbus_pkg::pin_level_e p);
        case (p)
            smbus_pkg::PIN_LOW:  pin_weight = 5'h01;
            smbus_pkg::PIN_HIGH: pin_weight = 5'h02;
            default:             pin_weight = 5'h00;
        endcase
    endfunction : pin_weight

    function automatic smbus_pkg::addr_t decode_addr(input smbus_pkg::pin_level_e p2,
                                                     input smbus_pkg::pin_level_e p1,
                                                     input smbus_pkg::pin_level_e p0);
        logic [4:0] idx;
        idx = 5'(pin_weight(p2) * `PIN_WEIGHT_2 + pin_weight(p1) * `PIN_WEIGHT_1
                 + pin_weight(p0));
        if (idx < `ADDR_GRP1_FIRST) begin
            decode_addr = 7'(`ADDR_GRP0_BASE + idx);
        end else if (idx < `ADDR_GRP2_FIRST) begin
            decode_addr = 7'(`ADDR_GRP1_BASE + (idx - `ADDR_GRP1_FIRST));
        end else begin
            decode_addr = 7'(`ADDR_GRP2_BASE + (idx - `ADDR_GRP2_FIRST));
        end
    endfunction : decode_addr

    logic             ready_q;
    logic             scl_q;
    logic             sda_q;
    logic             active;
    logic             got_bit;
    logic             rw;
    logic             mack;
    logic             stretching;
    logic [3:0]       bit_cnt;
    logic [1:0]       byte_idx;
    logic [7:0]       sh;
    logic [7:0]       out_sh;
    logic [7:0]       tx_hi;
    logic [7:0]       thr_lo;
    logic [23:0]      low_cnt;
    logic [23:0]      stretch_cnt;
    logic             scl_oe;
    logic             sda_oe;
    logic             line_lvl;

    wire ready_w       = enable_i && vdd_ok_i && vref_ok_i;
    wire start_w       = scl_q && bus.scl && sda_q && !bus.sda;
    wire stop_w        = scl_q && bus.scl && !sda_q && bus.sda;
    wire rise_w        = !scl_q && bus.scl;
    wire fall_w        = scl_q && !bus.scl;
    wire timeout_w     = active && (low_cnt >= 24'(TIMEOUT_CYC));
    wire stretch_ovf_w = active && (stretch_cnt >= 24'(STRETCH_CYC));
    wire abort_w       = timeout_w || stretch_ovf_w || (active && !addr_valid_o);
    wire addr_hit_w    = (sh[7:1] == addr_o);
    wire tx_phase_w    = rw && (byte_idx != `BYTE_ADDR);

    assign bus.t_scl_o  = line_lvl;
    assign bus.t_sda_o  = line_lvl;
    assign bus.t_scl_oe = scl_oe;
    assign bus.t_sda_oe = sda_oe;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ready_q      <= 1'b0;
            addr_o       <= '0;
            addr_valid_o <= 1'b0;
            line_lvl     <= 1'b0;
        end else begin
            ready_q  <= ready_w;
            line_lvl <= 1'b0;
            if (ready_w && !ready_q) begin
                addr_o       <= decode_addr(addr_sel_pin2_i, addr_sel_pin1_i, addr_sel_pin0_i);
                addr_valid_o <= 1'b1;
            end else if (!ready_w) begin
                addr_valid_o <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            low_cnt     <= '0;
            stretch_cnt <= '0;
        end else begin
            low_cnt <= (!active || bus.scl) ? '0 : low_cnt + 24'h000001;
            if (start_w || !active) begin
                stretch_cnt <= '0;
            end else if (scl_oe) begin
                stretch_cnt <= stretch_cnt + 24'h000001;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scl_q           <= 1'b1;
            sda_q           <= 1'b1;
            active          <= 1'b0;
            got_bit         <= 1'b0;
            rw              <= 1'b0;
            mack            <= 1'b0;
            stretching      <= 1'b0;
            bit_cnt         <= '0;
            byte_idx        <= `BYTE_ADDR;
            sh              <= '0;
            out_sh          <= '0;
            tx_hi           <= '0;
            thr_lo          <= '0;
            scl_oe          <= 1'b0;
            sda_oe          <= 1'b0;
            threshold_o     <= '0;
            threshold_we_o  <= 1'b0;
            telemetry_req_o <= 1'b0;
            bus_reset_o     <= 1'b0;
        end else begin
            scl_q           <= bus.scl;
            sda_q           <= bus.sda;
            threshold_we_o  <= 1'b0;
            telemetry_req_o <= 1'b0;
            bus_reset_o     <= 1'b0;
            if (abort_w) begin
                active      <= 1'b0;
                stretching  <= 1'b0;
                scl_oe      <= 1'b0;
                sda_oe      <= 1'b0;
                bus_reset_o <= timeout_w || stretch_ovf_w;
            end else if (stop_w) begin
                active     <= 1'b0;
                stretching <= 1'b0;
                scl_oe     <= 1'b0;
                sda_oe     <= 1'b0;
            end else if (start_w) begin
                active   <= addr_valid_o;
                got_bit  <= 1'b0;
                rw       <= 1'b0;
                bit_cnt  <= '0;
                byte_idx <= `BYTE_ADDR;
                sda_oe   <= 1'b0;
            end else if (active && stretching) begin
                if (telemetry_valid_i) begin
                    stretching <= 1'b0;
                    out_sh     <= telemetry_i[7:0];
                    tx_hi      <= telemetry_i[15:8];
                    sda_oe     <= !telemetry_i[7];
                end
            end else if (active && scl_oe && !stretching) begin
                // Data settles a cycle before the clock is let go, so no false start appears.
                scl_oe <= 1'b0;
            end else if (active && rise_w) begin
                got_bit <= 1'b1;
                if (bit_cnt == `BIT_ACK) begin
                    mack <= !bus.sda;
                end else begin
                    sh <= {sh[6:0], bus.sda};
                end
            end else if (active && fall_w && got_bit) begin
                got_bit <= 1'b0;
                if (bit_cnt == `BIT_LAST) begin
                    bit_cnt <= `BIT_ACK;
                    if (byte_idx == `BYTE_ADDR) begin
                        active <= addr_hit_w;
                        sda_oe <= addr_hit_w;
                        rw     <= sh[0];
                    end else if (!rw) begin
                        sda_oe <= 1'b1;
                        if (byte_idx == `BYTE_LO) begin
                            thr_lo <= sh;
                        end else if (byte_idx == `BYTE_HI) begin
                            threshold_o    <= {sh, thr_lo};
                            threshold_we_o <= 1'b1;
                        end
                    end else begin
                        sda_oe <= 1'b0;
                    end
                end else if (bit_cnt == `BIT_ACK) begin
                    bit_cnt  <= '0;
                    byte_idx <= (byte_idx == `BYTE_MAX) ? `BYTE_MAX : byte_idx + 2'h1;
                    sda_oe   <= 1'b0;
                    if (rw && byte_idx == `BYTE_ADDR) begin
                        // Hold the clock low until the sample is ready.
                        stretching      <= 1'b1;
                        scl_oe          <= 1'b1;
                        telemetry_req_o <= 1'b1;
                    end else if (rw && byte_idx == `BYTE_LO && mack) begin
                        out_sh <= tx_hi;
                        sda_oe <= !tx_hi[7];
                    end else if (rw) begin
                        active <= 1'b0;
                    end
                end else begin
                    bit_cnt <= bit_cnt + 4'h1;
                    if (tx_phase_w) begin
                        sda_oe <= !out_sh[6];
                        out_sh <= {out_sh[6:0], 1'b0};
                    end
                end
            end
        end
    end

endmodule : smbus_target_end

// ===== logic/smbus_host_end.sv
`include "smbus_addr_regs.svh"

module smbus_host_end #(
    parameter int HALF_CYC    = `T_SCL_HALF_NS / `CLK_PERIOD_NS,
    parameter int TIMEOUT_CYC = `T_TIMEOUT_MIN_US * `CLK_FREQ_MHZ
) (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             req_i,
    input  wire logic             rw_i,
    input  wire smbus_pkg::addr_t target_i,
    input  wire smbus_pkg::word_t wdata_i,
    output logic                  busy_o,
    output logic                  done_o,
    output logic                  nack_o,
    output logic                  timeout_o,
    output smbus_pkg::word_t      rdata_o,
    smbus_if.host                 bus
);

    smbus_pkg::host_state_e state;
    logic [23:0]            cnt;
    logic [3:0]             bit_cnt;
    logic [1:0]             byte_idx;
    logic [7:0]             sh;
    logic                   rw;
    smbus_pkg::addr_t       target;
    smbus_pkg::word_t       wdata;
    logic                   scl_oe;
    logic                   sda_oe;
    logic                   line_lvl;

    // Everything the byte depends on is an argument, so the wire below follows each change.
    function automatic logic [7:0] tx_byte(input logic [1:0]       idx,
                                           input smbus_pkg::addr_t tgt,
                                           input logic             dir,
                                           input smbus_pkg::word_t wd);
        case (idx)
            `BYTE_ADDR: tx_byte = {tgt, dir};
            `BYTE_LO:   tx_byte = wd[7:0];
            default:    tx_byte = wd[15:8];
        endcase
    endfunction : tx_byte

    wire half_w     = (cnt >= 24'(HALF_CYC));
    wire rx_w       = rw && (byte_idx != `BYTE_ADDR);
    wire [7:0] tx_w = tx_byte(byte_idx, target, rw, wdata);
    wire [3:0] bi_w = `BIT_LAST - bit_cnt;

    assign bus.h_scl_o  = line_lvl;
    assign bus.h_sda_o  = line_lvl;
    assign bus.h_scl_oe = scl_oe;
    assign bus.h_sda_oe = sda_oe;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state     <= smbus_pkg::H_IDLE;
            cnt       <= '0;
            bit_cnt   <= '0;
            byte_idx  <= `BYTE_ADDR;
            sh        <= '0;
            rw        <= 1'b0;
            target    <= '0;
            wdata     <= '0;
            scl_oe    <= 1'b0;
            sda_oe    <= 1'b0;
            line_lvl  <= 1'b0;
            busy_o    <= 1'b0;
            done_o    <= 1'b0;
            nack_o    <= 1'b0;
            timeout_o <= 1'b0;
            rdata_o   <= '0;
        end else begin
            done_o    <= 1'b0;
            timeout_o <= 1'b0;
            line_lvl  <= 1'b0;
            cnt       <= cnt + 24'h000001;
            case (state)
                smbus_pkg::H_IDLE: begin
                    cnt <= '0;
                    if (req_i && bus.scl && bus.sda) begin
                        wdata    <= wdata_i;
                        rw       <= rw_i;
                        target   <= target_i;
                        busy_o   <= 1'b1;
                        nack_o   <= 1'b0;
                        byte_idx <= `BYTE_ADDR;
                        bit_cnt  <= '0;
                        sda_oe   <= 1'b1;
                        state    <= smbus_pkg::H_START;
                    end
                end
                smbus_pkg::H_START: begin
                    if (half_w) begin
                        scl_oe <= 1'b1;
                        cnt    <= '0;
                        state  <= smbus_pkg::H_LOW;
                    end
                end
                smbus_pkg::H_LOW: begin
                    if (cnt == '0) begin
                        if (bit_cnt == `BIT_ACK) begin
                            sda_oe <= rx_w && (byte_idx == `BYTE_LO);
                        end else begin
                            sda_oe <= !rx_w && !tx_w[bi_w[2:0]];
                        end
                    end
                    if (half_w) begin
                        scl_oe <= 1'b0;
                        cnt    <= '0;
                        state  <= smbus_pkg::H_RISE;
                    end
                end
                smbus_pkg::H_RISE: begin
                    if (bus.scl) begin
                        cnt   <= '0;
                        state <= smbus_pkg::H_HIGH;
                    end else if (cnt >= 24'(TIMEOUT_CYC)) begin
                        sda_oe    <= 1'b0;
                        busy_o    <= 1'b0;
                        timeout_o <= 1'b1;
                        state     <= smbus_pkg::H_IDLE;
                    end
                end
                smbus_pkg::H_HIGH: begin
                    if (half_w) begin
                        scl_oe <= 1'b1;
                        cnt    <= '0;
                        state  <= smbus_pkg::H_LOW;
                        if (bit_cnt != `BIT_ACK) begin
                            sh      <= {sh[6:0], bus.sda};
                            bit_cnt <= bit_cnt + 4'h1;
                        end else begin
                            bit_cnt <= '0;
                            if (rx_w && byte_idx == `BYTE_LO) begin
                                rdata_o[7:0] <= sh;
                            end else if (rx_w) begin
                                rdata_o[15:8] <= sh;
                            end
                            if (!rx_w && bus.sda) begin
                                nack_o <= 1'b1;
                                state  <= smbus_pkg::H_STOP1;
                            end else if (byte_idx == `BYTE_HI) begin
                                state <= smbus_pkg::H_STOP1;
                            end else begin
                                byte_idx <= byte_idx + 2'h1;
                            end
                        end
                    end
                end
                smbus_pkg::H_STOP1: begin
                    sda_oe <= 1'b1;
                    if (half_w) begin
                        scl_oe <= 1'b0;
                        cnt    <= '0;
                        state  <= smbus_pkg::H_STOP2;
                    end
                end
                smbus_pkg::H_STOP2: begin
                    if (half_w && bus.scl) begin
                        sda_oe <= 1'b0;
                        busy_o <= 1'b0;
                        done_o <= 1'b1;
                        state  <= smbus_pkg::H_IDLE;
                    end
                end
                default: begin
                    scl_oe <= 1'b0;
                    sda_oe <= 1'b0;
                    busy_o <= 1'b0;
                    state  <= smbus_pkg::H_IDLE;
                end
            endcase
        end
    end

endmodule : smbus_host_end

// ===== tb/smbus_address_select_timeout_properties.sv
module smbus_address_select_timeout_properties #(
    parameter int TIMEOUT_CYC = 2000,
    parameter int STRETCH_CYC = 1000
) (
    input logic                  clk_i,
    input logic                  rst_n_i,
    input logic                  scl,
    input logic                  sda,
    input logic                  t_scl_o,
    input logic                  t_scl_oe,
    input logic                  t_sda_o,
    input logic                  t_sda_oe,
    input logic                  enable_i,
    input logic                  vdd_ok_i,
    input logic                  vref_ok_i,
    input smbus_pkg::pin_level_e addr_sel_pin0_i,
    input smbus_pkg::pin_level_e addr_sel_pin1_i,
    input smbus_pkg::pin_level_e addr_sel_pin2_i,
    input smbus_pkg::addr_t      addr_o,
    input logic                  addr_valid_o,
    input logic                  bus_reset_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // A few cycles of slack cover the registered release after the limit is seen.
    localparam int StretchMax = STRETCH_CYC + 4;
    localparam int LowMax     = TIMEOUT_CYC * 7 / 5;
    int unsigned stretch_cnt;
    int unsigned low_cnt;
    logic        sda_q;
    wire         ready      = enable_i && vdd_ok_i && vref_ok_i;
    wire         start_seen = scl && !sda && sda_q;
    wire         stop_seen  = scl && sda && !sda_q;

    function automatic smbus_pkg::addr_t decode(input int idx);
        return (idx < 8) ? 7'h40 + 7'(idx) : (idx < 16) ? 7'h10 + 7'(idx - 8) : 7'h50 + 7'(idx - 16);
    endfunction : decode

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stretch_cnt <= '0;
            low_cnt     <= '0;
            sda_q       <= 1'b1;
        end else begin
            sda_q       <= sda;
            stretch_cnt <= (bus_reset_o || start_seen || stop_seen) ? '0 : stretch_cnt + 32'(t_scl_oe);
            low_cnt     <= scl ? '0 : low_cnt + 1;
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_target_scl_drain: assert property (t_scl_oe |-> !t_scl_o)
        else $error("target drives scl high");
    a_target_sda_drain: assert property (t_sda_oe |-> !t_sda_o)
        else $error("target drives sda high");
    a_reset_releases_lines: assert property (bus_reset_o |=> !t_scl_oe && !t_sda_oe)
        else $error("lines still held after bus reset");
    a_stretch_total_bound: assert property (stretch_cnt <= StretchMax)
        else $error("cumulative stretch over limit");
    a_scl_low_bound: assert property (low_cnt <= LowMax)
        else $error("clock low beyond abandon limit");
    a_ready_latches_addr: assert property ($rose(ready) |=> addr_valid_o)
        else $error("address not latched after ready");
    a_not_ready_invalid: assert property (!ready |=> !addr_valid_o)
        else $error("address valid without ready");
    a_addr_held_stable: assert property (addr_valid_o && $past(addr_valid_o) |-> $stable(addr_o))
        else $error("latched address changed");
    a_addr_decode_table: assert property ($rose(addr_valid_o) |-> addr_o == decode(
            9 * int'($past(addr_sel_pin2_i)) + 3 * int'($past(addr_sel_pin1_i))
            + int'($past(addr_sel_pin0_i))))
        else $error("decoded address wrong");
endmodule : smbus_address_select_timeout_properties

// ===== tb/smbus_address_select_timeout_bench.sv
module smbus_address_select_timeout_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TimeoutT = 2000;
    localparam int StretchT = 1000;
    // The host gives up before the target's stretch limit, so both recoveries show in one run.
    localparam int TimeoutH = 800;
    logic clk_i, rst_n_i, enable_i, vdd_ok_i, vref_ok_i, telemetry_valid_i;
    logic req_i, rw_i, threshold_we_o, telemetry_req_o, bus_reset_o, addr_valid_o;
    logic busy_o, done_o, nack_o, timeout_o;
    smbus_pkg::pin_level_e p0, p1, p2;
    smbus_pkg::addr_t      addr_o, target_i;
    smbus_pkg::word_t      telemetry_i, wdata_i, threshold_o, rdata_o;
    int                    num_errors, tests_run, to_at, rst_at, we_seen;
    smbus_pkg::addr_t      rows [27] = '{7'h40, 7'h41, 7'h42, 7'h43, 7'h44, 7'h45, 7'h46, 7'h47,
        7'h10, 7'h11, 7'h12, 7'h13, 7'h14, 7'h15, 7'h16, 7'h17,
        7'h50, 7'h51, 7'h52, 7'h53, 7'h54, 7'h55, 7'h56, 7'h57, 7'h58, 7'h59, 7'h5a};

    smbus_if bus_if ();
    smbus_target_end #(.TIMEOUT_CYC(TimeoutT), .STRETCH_CYC(StretchT)) smbus_target_end_inst (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .enable_i(enable_i), .vdd_ok_i(vdd_ok_i),
        .vref_ok_i(vref_ok_i), .addr_sel_pin0_i(p0), .addr_sel_pin1_i(p1), .addr_sel_pin2_i(p2),
        .telemetry_i(telemetry_i), .telemetry_valid_i(telemetry_valid_i), .addr_o(addr_o),
        .addr_valid_o(addr_valid_o), .threshold_o(threshold_o), .threshold_we_o(threshold_we_o),
        .telemetry_req_o(telemetry_req_o), .bus_reset_o(bus_reset_o), .bus(bus_if));
    smbus_host_end #(.HALF_CYC(4), .TIMEOUT_CYC(TimeoutH)) smbus_host_end_inst (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req_i), .rw_i(rw_i), .target_i(target_i),
        .wdata_i(wdata_i), .busy_o(busy_o), .done_o(done_o), .nack_o(nack_o),
        .timeout_o(timeout_o), .rdata_o(rdata_o), .bus(bus_if));
    smbus_address_select_timeout_properties #(.TIMEOUT_CYC(TimeoutT), .STRETCH_CYC(StretchT)) chk (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .scl(bus_if.scl), .sda(bus_if.sda),
        .t_scl_o(bus_if.t_scl_o), .t_scl_oe(bus_if.t_scl_oe), .t_sda_o(bus_if.t_sda_o),
        .t_sda_oe(bus_if.t_sda_oe), .enable_i(enable_i), .vdd_ok_i(vdd_ok_i),
        .vref_ok_i(vref_ok_i), .addr_sel_pin0_i(p0), .addr_sel_pin1_i(p1), .addr_sel_pin2_i(p2),
        .addr_o(addr_o), .addr_valid_o(addr_valid_o), .bus_reset_o(bus_reset_o));

    always @(posedge clk_i) we_seen <= !rst_n_i ? 0 : we_seen + int'(threshold_we_o === 1'b1);

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic clocks(input int n);
        repeat (n) @(posedge clk_i);
    endtask : clocks

    task automatic set_pins(input int idx);
        p0 <= smbus_pkg::pin_level_e'(2'(idx % 3));
        p1 <= smbus_pkg::pin_level_e'(2'((idx / 3) % 3));
        p2 <= smbus_pkg::pin_level_e'(2'(idx / 9));
    endtask : set_pins

    task automatic issue(input logic rw, input smbus_pkg::addr_t a, input smbus_pkg::word_t w);
        req_i    <= 1'b1;
        rw_i     <= rw;
        target_i <= a;
        wdata_i  <= w;
        do clocks(1); while (busy_o !== 1'b1);
        req_i <= 1'b0;
    endtask : issue

    task automatic wait_end();
        int n;
        n = 0;
        while (done_o !== 1'b1 && timeout_o !== 1'b1 && n < 5000) begin
            clocks(1);
            n++;
        end
        if (n >= 5000) begin
            num_errors++;
        end
        clocks(2);
    endtask : wait_end

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : complete_run

    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    initial begin
        clocks(60000);
        num_errors++;
        complete_run();
    end

    initial begin
        rst_n_i = 1'b0;
        {enable_i, req_i, rw_i, telemetry_valid_i} = 4'h0;
        {vdd_ok_i, vref_ok_i} = 2'h3;
        {p0, p1, p2} = {3{smbus_pkg::PIN_OPEN}};
        {target_i, telemetry_i, wdata_i} = '0;
        {num_errors, tests_run, to_at, rst_at} = {-32'sd1, 32'sd0, -32'sd1, -32'sd1};
        num_errors = 0;
        clocks(3);
        rst_n_i <= 1'b1;
        clocks(2);
        check({15'h0, addr_valid_o}, 16'h0);
        for (int i = 0; i < 27; i++) begin
            enable_i <= 1'b0;
            set_pins(i);
            clocks(2);
            enable_i <= 1'b1;
            clocks(3);
            check({9'h0, addr_o}, {9'h0, rows[i]});
            check({15'h0, addr_valid_o}, 16'h1);
        end
        $display("test address table done");
        set_pins(13);
        clocks(3);
        check({9'h0, addr_o}, 16'h005a);
        vdd_ok_i <= 1'b0;
        set_pins(0);
        clocks(2);
        check({15'h0, addr_valid_o}, 16'h0);
        vdd_ok_i <= 1'b1;
        clocks(3);
        check({9'h0, addr_o}, 16'h0040);
        $display("test relatch done");
        issue(1'b0, 7'h40, 16'h8001);
        wait_end();
        check(threshold_o, 16'h8001);
        check({15'h0, nack_o}, 16'h0);
        check(16'(we_seen), 16'h1);
        issue(1'b0, 7'h41, 16'h1234);
        wait_end();
        check({15'h0, nack_o}, 16'h1);
        check(threshold_o, 16'h8001);
        check(16'(we_seen), 16'h1);
        $display("test write done");
        telemetry_i <= 16'hff85;
        issue(1'b1, 7'h40, 16'h0000);
        for (int n = 0; n < 2000 && telemetry_req_o !== 1'b1; n++) clocks(1);
        clocks(5);
        telemetry_valid_i <= 1'b1;
        wait_end();
        check(rdata_o, 16'hff85);
        $display("test read done");
        telemetry_valid_i <= 1'b0;
        issue(1'b1, 7'h40, 16'h0000);
        for (int n = 0; n < 4000; n++) begin
            clocks(1);
            if (timeout_o === 1'b1 && to_at < 0) to_at = n;
            if (bus_reset_o === 1'b1 && rst_at < 0) rst_at = n;
        end
        check(16'(to_at >= TimeoutH && to_at < TimeoutH * 7 / 5 + 300), 16'h1);
        check(16'(rst_at >= StretchT && rst_at > to_at), 16'h1);
        check({14'h0, bus_if.scl, bus_if.sda}, 16'h3);
        check({15'h0, busy_o}, 16'h0);
        $display("test stretch overrun done");
        complete_run();
    end
endmodule : smbus_address_select_timeout_bench
